// ---- hw/uecs_cfg.svh ----
// Bit positions and fixed counts for the endpoint-zero control and status block.
// Included by the package and both ends; holds definitions only.
`ifndef UECS_CFG_SVH
`define UECS_CFG_SVH

// Width of each register view.
`define UECS_REG_W 16
// Register view select codes.
`define UECS_SEL_PERI 1'b0
`define UECS_SEL_HOST 1'b1

// Peripheral view bit positions.
`define UECS_P_FLUSH 8
`define UECS_P_SERV_END 7
`define UECS_P_SERV_RX 6
`define UECS_P_ISSUE_STALL 5
`define UECS_P_EARLY_END 4
`define UECS_P_LAST_DATA 3
`define UECS_P_STALL_SENT 2
`define UECS_P_TX_READY 1
`define UECS_P_RX_READY 0

// Host view bit positions.
`define UECS_H_TOG_WREN 10
`define UECS_H_TOGGLE 9
`define UECS_H_FLUSH 8
`define UECS_H_NAK_TIMEOUT 7
`define UECS_H_STATUS 6
`define UECS_H_IN_REQ 5
`define UECS_H_ERROR 4
`define UECS_H_SETUP 3
`define UECS_H_STALL_RCVD 2
`define UECS_H_TX_READY 1
`define UECS_H_RX_READY 0

// Attempts without any answer before the error flag is raised.
`define UECS_MAX_TRIES 2'h3
// Defaults for widths that nothing fixes.
`define UECS_PTR_W_DEFAULT 6
`define UECS_NAK_W_DEFAULT 8

`endif

// ---- hw/uecs_dev_end.sv ----
// Endpoint-zero control and status logic of a dual-role USB controller.
// Assumes a partner on the link interface and software on the register port.
`include "uecs_cfg.svh"

module uecs_dev_end #(
	parameter int PTR_W = `UECS_PTR_W_DEFAULT,
	parameter int NAK_W = `UECS_NAK_W_DEFAULT
) (
	input wire logic clock,
	input wire logic reset_n,
	uecs_link_if.dev link,
	input wire logic host_mode,
	input wire logic reg_write,
	input wire logic reg_sel,
	input wire logic [`UECS_REG_W-1:0] reg_wdata,
	output logic [`UECS_REG_W-1:0] reg_rdata,
	input wire logic [NAK_W-1:0] nak_limit,
	input wire logic tx_irq_enable,
	input wire logic fifo_step,
	output logic [PTR_W-1:0] fifo_ptr,
	output logic irq
);

	typedef struct packed {
		logic tx_ready;
		logic rx_ready;
		logic early_end;
		logic last_data;
		logic stall_req;
		logic stall_sent;
		logic tog_wren;
		logic toggle;
		logic nak_timeout;
		logic status_req;
		logic in_req;
		logic error;
		logic setup_sel;
		logic stall_rcvd;
		logic [1:0] tries;
		logic [NAK_W-1:0] naks;
		logic [PTR_W-1:0] ptr;
		logic [`UECS_REG_W-1:0] rdata;
		logic irq;
		logic req;
		uecs_pkg::uecs_pkt_t kind;
		logic req_tog;
	} uecs_dev_state_t;

	uecs_dev_state_t s;
	uecs_dev_state_t next_s;

	////////////////////////////////////////////////////////////////////////////
	// Read views. Write-only command bits always read as zero.
	function automatic logic [`UECS_REG_W-1:0] peri_view(input uecs_dev_state_t v);
		logic [`UECS_REG_W-1:0] r;
		r = '0;
		r[`UECS_P_EARLY_END] = v.early_end;
		r[`UECS_P_STALL_SENT] = v.stall_sent;
		r[`UECS_P_TX_READY] = v.tx_ready;
		r[`UECS_P_RX_READY] = v.rx_ready;
		return r;
	endfunction

	function automatic logic [`UECS_REG_W-1:0] host_view(input uecs_dev_state_t v);
		logic [`UECS_REG_W-1:0] r;
		r = '0;
		r[`UECS_H_TOGGLE] = v.toggle;
		r[`UECS_H_NAK_TIMEOUT] = v.nak_timeout;
		r[`UECS_H_STATUS] = v.status_req;
		r[`UECS_H_IN_REQ] = v.in_req;
		r[`UECS_H_ERROR] = v.error;
		r[`UECS_H_SETUP] = v.setup_sel;
		r[`UECS_H_STALL_RCVD] = v.stall_rcvd;
		r[`UECS_H_TX_READY] = v.tx_ready;
		r[`UECS_H_RX_READY] = v.rx_ready;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state. Software writes are applied first and link events after them,
	// so a flag that hardware sets in the cycle software clears it stays set.
	always_comb begin
		logic [NAK_W-1:0] nak_next;
		logic flush_ok;
		nak_next = s.naks + NAK_W'(1);
		flush_ok = s.tx_ready || s.rx_ready;
		next_s = s;
		next_s.irq = 1'b0;

		// The pointer walks with each FIFO access; a flush below overrides it.
		if (fifo_step) begin
			next_s.ptr = s.ptr + PTR_W'(1);
		end

		if (reg_write && reg_sel == `UECS_SEL_PERI) begin
			if (reg_wdata[`UECS_P_FLUSH] && flush_ok) begin
				next_s.tx_ready = 1'b0;
				next_s.rx_ready = 1'b0;
				next_s.ptr = '0;
			end
			if (reg_wdata[`UECS_P_SERV_END]) begin
				next_s.early_end = 1'b0;
			end
			if (reg_wdata[`UECS_P_SERV_RX]) begin
				next_s.rx_ready = 1'b0;
			end
			if (reg_wdata[`UECS_P_ISSUE_STALL]) begin
				next_s.stall_req = 1'b1;
			end
			if (reg_wdata[`UECS_P_LAST_DATA]) begin
				next_s.last_data = 1'b1;
			end
			if (!reg_wdata[`UECS_P_STALL_SENT]) begin
				next_s.stall_sent = 1'b0;
			end
			if (reg_wdata[`UECS_P_TX_READY]) begin
				next_s.tx_ready = 1'b1;
			end
		end else if (reg_write) begin
			if (reg_wdata[`UECS_H_FLUSH] && flush_ok) begin
				next_s.tx_ready = 1'b0;
				next_s.rx_ready = 1'b0;
				next_s.ptr = '0;
			end
			// One enabled write moves the toggle and uses the enable up.
			if (s.tog_wren) begin
				next_s.toggle = reg_wdata[`UECS_H_TOGGLE];
				next_s.tog_wren = 1'b0;
			end else begin
				next_s.tog_wren = reg_wdata[`UECS_H_TOG_WREN];
			end
			if (!reg_wdata[`UECS_H_NAK_TIMEOUT]) begin
				next_s.nak_timeout = 1'b0;
			end
			if (!reg_wdata[`UECS_H_ERROR]) begin
				next_s.error = 1'b0;
			end
			if (!reg_wdata[`UECS_H_STALL_RCVD]) begin
				next_s.stall_rcvd = 1'b0;
			end
			if (!reg_wdata[`UECS_H_RX_READY]) begin
				next_s.rx_ready = 1'b0;
			end
			next_s.status_req = reg_wdata[`UECS_H_STATUS];
			next_s.setup_sel = reg_wdata[`UECS_H_SETUP];
			next_s.in_req = reg_wdata[`UECS_H_IN_REQ];
			if (reg_wdata[`UECS_H_TX_READY]) begin
				next_s.tx_ready = 1'b1;
			end
			// A fresh request starts its NAK and retry counts from zero.
			if (reg_wdata[`UECS_H_TX_READY] || reg_wdata[`UECS_H_IN_REQ]) begin
				next_s.naks = '0;
				next_s.tries = '0;
			end
		end

		if (link.rsp) begin
			unique case (link.rsp_kind)
				uecs_pkg::rs_ack: begin
					if (s.req && s.kind == uecs_pkg::pk_stall) begin
						next_s.stall_req = 1'b0;
						next_s.stall_sent = 1'b1;
					end else if (s.req && s.kind != uecs_pkg::pk_in) begin
						next_s.tx_ready = 1'b0;
						next_s.irq = tx_irq_enable;
						if (host_mode) begin
							next_s.toggle = !s.req_tog;
							next_s.setup_sel = 1'b0;
							next_s.status_req = 1'b0;
							next_s.naks = '0;
							next_s.tries = '0;
						end
					end
				end
				uecs_pkg::rs_data: begin
					next_s.rx_ready = 1'b1;
					next_s.irq = 1'b1;
					if (host_mode && s.req && s.kind == uecs_pkg::pk_in) begin
						next_s.in_req = 1'b0;
						next_s.toggle = !s.req_tog;
						next_s.status_req = 1'b0;
						next_s.naks = '0;
						next_s.tries = '0;
					end
				end
				uecs_pkg::rs_nak: begin
					// A zero limit never times out.
					if (host_mode && s.req) begin
						if (nak_limit != '0 && nak_next >= nak_limit) begin
							next_s.nak_timeout = 1'b1;
							next_s.naks = '0;
						end else begin
							next_s.naks = nak_next;
						end
					end
				end
				uecs_pkg::rs_stall: begin
					if (host_mode && s.req) begin
						next_s.stall_rcvd = 1'b1;
						next_s.tx_ready = 1'b0;
						next_s.in_req = 1'b0;
					end
				end
				uecs_pkg::rs_none: begin
					if (host_mode && s.req) begin
						if (s.tries == `UECS_MAX_TRIES - 2'h1) begin
							next_s.error = 1'b1;
							next_s.irq = 1'b1;
							next_s.tx_ready = 1'b0;
							next_s.in_req = 1'b0;
							next_s.tries = '0;
						end else begin
							next_s.tries = s.tries + 2'h1;
						end
					end
				end
				uecs_pkg::rs_ctl_end: begin
					if (!host_mode && !s.last_data) begin
						next_s.early_end = 1'b1;
						next_s.irq = 1'b1;
						next_s.tx_ready = 1'b0;
						next_s.rx_ready = 1'b0;
						next_s.ptr = '0;
					end
					next_s.last_data = 1'b0;
				end
			endcase
		end

		// Request to the link. A stall outranks data in peripheral mode; a host
		// halted by a NAK timeout issues nothing until software clears it.
		if (!host_mode) begin
			next_s.req = next_s.stall_req || next_s.tx_ready;
			next_s.kind = next_s.stall_req ? uecs_pkg::pk_stall : uecs_pkg::pk_data;
			next_s.req_tog = next_s.toggle;
		end else begin
			next_s.req = !next_s.nak_timeout && (next_s.tx_ready || next_s.in_req);
			if (next_s.tx_ready) begin
				next_s.kind = next_s.setup_sel ? uecs_pkg::pk_setup : uecs_pkg::pk_out;
			end else begin
				next_s.kind = uecs_pkg::pk_in;
			end
			// Status stages go as DATA1; setup packets go as DATA0 unless status_req is also set.
			if (next_s.status_req) begin
				next_s.req_tog = 1'b1;
			end else if (next_s.tx_ready && next_s.setup_sel) begin
				next_s.req_tog = 1'b0;
			end else begin
				next_s.req_tog = next_s.toggle;
			end
		end

		next_s.rdata = (reg_sel == `UECS_SEL_HOST) ? host_view(next_s) : peri_view(next_s);
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign link.req = s.req;
	assign link.req_kind = s.kind;
	assign link.req_toggle = s.req_tog;
	assign reg_rdata = s.rdata;
	assign fifo_ptr = s.ptr;
	assign irq = s.irq;

endmodule

// ---- hw/uecs_link_if.sv ----
// Transaction-level link between the endpoint-zero controller and its USB partner.
// Both ends run on the same clock; the bench joins them through this interface.
interface uecs_link_if;
	logic req;
	uecs_pkg::uecs_pkt_t req_kind;
	logic req_toggle;
	logic rsp;
	uecs_pkg::uecs_rsp_t rsp_kind;

	// Controller end.
	modport dev (output req, output req_kind, output req_toggle, input rsp, input rsp_kind);
	// Partner end.
	modport partner (input req, input req_kind, input req_toggle, output rsp, output rsp_kind);
endinterface

// ---- hw/uecs_partner_end.sv ----
// USB partner end: answers the controller's requests as the user side directs.
// Assumes the user side holds answer_kind steady while a request is pending.
`include "uecs_cfg.svh"

module uecs_partner_end (
	input wire logic clock,
	input wire logic reset_n,
	uecs_link_if.partner link,
	input wire logic answer_en,
	input uecs_pkg::uecs_rsp_t answer_kind,
	input wire logic send_data,
	input wire logic end_transfer,
	output logic got_req,
	output uecs_pkg::uecs_pkt_t got_kind,
	output logic got_toggle
);

	typedef struct packed {
		logic rsp;
		uecs_pkg::uecs_rsp_t rsp_kind;
		logic got_req;
		uecs_pkg::uecs_pkt_t got_kind;
		logic got_toggle;
	} uecs_partner_state_t;

	uecs_partner_state_t s;
	uecs_partner_state_t next_s;

	////////////////////////////////////////////////////////////////////////////
	// Unsolicited events go first; a pending request is answered only when the
	// previous cycle carried no answer, because the controller drops its request
	// one cycle after it sees one and must not be answered twice.
	always_comb begin
		next_s = s;
		next_s.rsp = 1'b0;
		next_s.got_req = 1'b0;
		if (send_data) begin
			next_s.rsp = 1'b1;
			next_s.rsp_kind = uecs_pkg::rs_data;
		end else if (end_transfer) begin
			next_s.rsp = 1'b1;
			next_s.rsp_kind = uecs_pkg::rs_ctl_end;
		end else if (link.req && !s.rsp && answer_en) begin
			next_s.rsp = 1'b1;
			next_s.rsp_kind = answer_kind;
			next_s.got_req = 1'b1;
			next_s.got_kind = link.req_kind;
			next_s.got_toggle = link.req_toggle;
		end
	end

	// State register.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s <= '{rsp: 1'b0, rsp_kind: uecs_pkg::rs_ack, got_req: 1'b0,
				got_kind: uecs_pkg::pk_data, got_toggle: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign link.rsp = s.rsp;
	assign link.rsp_kind = s.rsp_kind;
	assign got_req = s.got_req;
	assign got_kind = s.got_kind;
	assign got_toggle = s.got_toggle;

endmodule

// ---- hw/uecs_pkg.sv ----
// Shared types for the endpoint-zero block and its link partner.
// Assumes the configuration header sits on the include path.
`include "uecs_cfg.svh"

package uecs_pkg;

	// What the controller asks the link to do.
	typedef enum logic [2:0] {
		pk_data,
		pk_stall,
		pk_setup,
		pk_out,
		pk_in
	} uecs_pkt_t;

	// What the link partner reports back.
	typedef enum logic [2:0] {
		rs_ack,
		rs_nak,
		rs_stall,
		rs_data,
		rs_none,
		rs_ctl_end
	} uecs_rsp_t;

endpackage

// ---- tb/uecs_monitor.sv ----
// Link checker for the endpoint-zero controller and its partner.
// Takes the link signals as plain inputs, placed beside the interface.
module uecs_monitor (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic req,
	input uecs_pkg::uecs_pkt_t req_kind,
	input wire logic req_toggle,
	input wire logic rsp,
	input uecs_pkg::uecs_rsp_t rsp_kind
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	// One attempt that drew no answer, and three of them two cycles apart.
	sequence no_answer;
		rsp && req && rsp_kind == uecs_pkg::rs_none;
	endsequence
	sequence three_tries;
		no_answer ##2 no_answer ##2 no_answer;
	endsequence
	// A retired request must leave the line at once, or it would be sent twice.
	chk_ack_drop: assert property (
		rsp && req && rsp_kind == uecs_pkg::rs_ack |=> !req)
		else $error("request held after ack");
	chk_stall_done: assert property (
		rsp && req && req_kind == uecs_pkg::pk_stall |=> !req [*2])
		else $error("stall request not retired");
	chk_rstall_drop: assert property (
		rsp && req && rsp_kind == uecs_pkg::rs_stall |=> !req)
		else $error("request held after stall");
	chk_error_drop: assert property (
		three_tries |=> !req)
		else $error("request held after three silent tries");
	chk_in_done: assert property (
		rsp && req && req_kind == uecs_pkg::pk_in && rsp_kind == uecs_pkg::rs_data |=> !req)
		else $error("in request held after data");
	chk_in_hold: assert property (
		req && !rsp && req_kind == uecs_pkg::pk_in
		|=> req && req_kind == uecs_pkg::pk_in && $stable(req_toggle))
		else $error("in request changed while pending");
	chk_setup_tog: assert property (
		req && req_kind == uecs_pkg::pk_setup |-> !req_toggle)
		else $error("setup sent with toggle one");
	chk_rsp_cause: assert property (
		rsp && rsp_kind inside {uecs_pkg::rs_ack, uecs_pkg::rs_nak, uecs_pkg::rs_stall,
		uecs_pkg::rs_none} |-> $past(req))
		else $error("handshake with no request");
endmodule

// ---- tb/usb_ep0_control_status_tb.sv ----
// Bench joining both link ends and driving their user sides.
// Assumes the package, interface and both ends are compiled first.
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED at %0t got %h exp %h", $time, a, e); end end
module usb_ep0_control_status_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic host_mode = 1'b0;
	logic reg_write = 1'b0;
	logic reg_sel = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic [7:0] nak_limit = 8'h00;
	logic tx_irq_enable = 1'b0;
	logic fifo_step = 1'b0;
	logic [5:0] fifo_ptr;
	logic irq;
	logic answer_en = 1'b0;
	uecs_pkg::uecs_rsp_t answer_kind = uecs_pkg::rs_ack;
	logic send_data = 1'b0;
	logic end_transfer = 1'b0;
	logic got_req;
	uecs_pkg::uecs_pkt_t got_kind;
	logic got_toggle;
	int miscompares = 0;
	int checks_done = 0;
	int n;
	uecs_link_if link ();
	////////////////////////////////////////
	// Both ends face each other; the checker watches the wire between.
	uecs_dev_end #(.PTR_W(6), .NAK_W(8)) i_uecs_dev_end (.clock(clock), .reset_n(reset_n),
		.link(link), .host_mode(host_mode), .reg_write(reg_write), .reg_sel(reg_sel),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .nak_limit(nak_limit),
		.tx_irq_enable(tx_irq_enable), .fifo_step(fifo_step), .fifo_ptr(fifo_ptr), .irq(irq));
	uecs_partner_end i_uecs_partner_end (.clock(clock), .reset_n(reset_n), .link(link),
		.answer_en(answer_en), .answer_kind(answer_kind), .send_data(send_data),
		.end_transfer(end_transfer), .got_req(got_req), .got_kind(got_kind),
		.got_toggle(got_toggle));
	uecs_monitor i_uecs_monitor (.clock(clock), .reset_n(reset_n), .req(link.req),
		.req_kind(link.req_kind), .req_toggle(link.req_toggle), .rsp(link.rsp),
		.rsp_kind(link.rsp_kind));
	// Free-running 100 MHz clock.
	always #5 clock = ~clock;
	////////////////////////////////////////
	// Prints the verdict and ends the run.
	task automatic wrap_up();
		if (miscompares == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// One-cycle register write into the selected view.
	task automatic wr(input int s, input logic [15:0] d);
		@(posedge clock);
		reg_sel <= 1'(s);
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	// Reads a view and compares it; the view trails the select by an edge.
	task automatic rd_chk(input int s, input logic [15:0] e);
		@(posedge clock);
		reg_sel <= 1'(s);
		repeat (2) @(posedge clock);
		#1;
		`CHK(reg_rdata, e)
	endtask
	// One-cycle pulse: 0 data from the partner, 1 transfer end, 2 fifo step.
	task automatic strobe(input int w);
		@(posedge clock);
		send_data <= (w == 0);
		end_transfer <= (w == 1);
		fifo_step <= (w == 2);
		@(posedge clock);
		{send_data, end_transfer, fifo_step} <= 3'h0;
	endtask
	// Waits for an answer, then lets the edge that consumes it pass.
	task automatic wait_ans();
		int i;
		for (i = 0; i < 40 && got_req !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		if (i == 40) begin
			miscompares++;
			wrap_up();
		end
		@(posedge clock);
		#1;
	endtask
	// Sets the answer the partner gives to the next request.
	task automatic ask(input uecs_pkg::uecs_rsp_t k);
		@(posedge clock);
		answer_kind <= k;
	endtask
	// Expected host view: toggle in bit 9, flag bits in bits 8 to 0.
	function automatic logic [15:0] host_word(input logic tog, input logic [8:0] flags);
		return {6'h00, tog, flags};
	endfunction
	////////////////////////////////////////
	// Peripheral role first, then host role; each step leaves flags clear.
	initial begin
		n = $urandom(65291);
		nak_limit <= 8'(1 + $urandom_range(3));
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		answer_en <= 1'b1;
		tx_irq_enable <= 1'b1;
		rd_chk(0, 16'h0000);
		rd_chk(1, 16'h0000);
		wr(0, 16'h0020);
		wait_ans();
		`CHK(got_kind, uecs_pkg::pk_stall)
		rd_chk(0, 16'h0004);
		wr(0, 16'h0004);
		rd_chk(0, 16'h0004);
		wr(0, 16'h0000);
		rd_chk(0, 16'h0000);
		wr(0, 16'h000A);
		wait_ans();
		`CHK(irq, 1'b1)
		strobe(1);
		rd_chk(0, 16'h0000);
		n = 1 + $urandom_range(4);
		repeat (n) strobe(2);
		wr(0, 16'h0100);
		#1;
		`CHK(fifo_ptr, 6'(n))
		strobe(0);
		// The interrupt pulse stands one cycle, one edge after the partner's answer.
		@(posedge clock);
		#1;
		`CHK(irq, 1'b1)
		rd_chk(0, 16'h0001);
		wr(0, 16'h0100);
		rd_chk(0, 16'h0000);
		`CHK(fifo_ptr, 6'h00)
		strobe(0);
		wr(0, 16'h0040);
		rd_chk(0, 16'h0000);
		strobe(0);
		strobe(1);
		@(posedge clock);
		#1;
		`CHK(irq, 1'b1)
		rd_chk(0, 16'h0010);
		wr(0, 16'h0080);
		rd_chk(0, 16'h0000);
		@(posedge clock);
		host_mode <= 1'b1;
		wr(1, 16'h0200);
		rd_chk(1, 16'h0000);
		wr(1, 16'h0400);
		wr(1, 16'h0200);
		rd_chk(1, 16'h0200);
		wr(1, 16'h0000);
		rd_chk(1, 16'h0200);
		ask(uecs_pkg::rs_data);
		wr(1, 16'h0020);
		wait_ans();
		`CHK(got_toggle, 1'b1)
		rd_chk(1, 16'h0001);
		wr(1, 16'h0000);
		ask(uecs_pkg::rs_ack);
		wr(1, 16'h0042);
		wait_ans();
		`CHK(got_toggle, 1'b1)
		rd_chk(1, 16'h0000);
		// The setup transfer also shows that a disabled tx interrupt stays quiet.
		ask(uecs_pkg::rs_ack);
		tx_irq_enable <= 1'b0;
		wr(1, 16'h000A);
		wait_ans();
		`CHK(irq, 1'b0)
		`CHK(got_kind, uecs_pkg::pk_setup)
		rd_chk(1, 16'h0200);
		ask(uecs_pkg::rs_stall);
		wr(1, 16'h0002);
		wait_ans();
		rd_chk(1, 16'h0204);
		wr(1, 16'h0004);
		rd_chk(1, 16'h0204);
		wr(1, 16'h0000);
		rd_chk(1, 16'h0200);
		ask(uecs_pkg::rs_none);
		wr(1, 16'h0002);
		repeat (3) wait_ans();
		`CHK(irq, 1'b1)
		rd_chk(1, host_word(1'b1, 9'h010));
		wr(1, 16'h0000);
		ask(uecs_pkg::rs_nak);
		wr(1, 16'h0002);
		repeat (nak_limit) wait_ans();
		rd_chk(1, host_word(1'b1, 9'h082));
		// Move the pointer first so that the host flush has something to reset.
		strobe(2);
		wr(1, 16'h0100);
		rd_chk(1, 16'h0200);
		`CHK(fifo_ptr, 6'h00)
		// A reset in mid-run must bring the toggle back to zero.
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd_chk(1, 16'h0000);
		wrap_up();
	end
endmodule
